//--- tkh_pkg.sv
// touch-key host command set: shared constants and types
package tkh_pkg;

  // command bytes
  localparam logic [7:0] CMD_NULL   = 8'h00;
  localparam logic [7:0] CMD_SETUP  = 8'h01;
  localparam logic [7:0] CMD_CAL    = 8'h03;
  localparam logic [7:0] CMD_RST    = 8'h04;
  localparam logic [7:0] CMD_GSTAT  = 8'h05;
  localparam logic [7:0] CMD_FIRST  = 8'h06;
  localparam logic [7:0] CMD_ALLDET = 8'h07;
  localparam logic [7:0] CMD_ALLERR = 8'h0B;
  localparam logic [7:0] CMD_LFLT   = 8'h0C;
  localparam logic [7:0] CMD_LAST   = 8'h0F;

  // acknowledge bytes and fixed response values
  localparam logic [7:0] ACK_SETUP = 8'hFE;
  localparam logic [7:0] NAK_CRC   = 8'h00;
  localparam logic [7:0] ACK_CAL   = 8'hFC;
  localparam logic [7:0] ACK_RST   = 8'hFB;
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [4:0] NO_KEY    = 5'h1F;
  localparam logic [7:0] IDLE_BYTE = 8'h00;

  // crc-8 of block and responses
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_SKIP = 8'h00;

  // setups block: data bytes before the crc byte
  localparam logic [6:0] BLK_LEN = 7'h64;

  // general status and first-key bit positions
  localparam int GS_COMM  = 6;
  localparam int GS_FMEA  = 5;
  localparam int GS_SYNC  = 3;
  localparam int GS_CALF  = 2;
  localparam int GS_CAL   = 1;
  localparam int GS_DET   = 0;
  localparam int FK_MULTI = 7;
  localparam int FK_ERR   = 6;

  // pin reset value and answer queue depth
  localparam logic [2:0] PIN_RST = 3'h1;
  localparam int         QDEPTH  = 4;

  // timeouts
  localparam int          CLK_KHZ = 125000;
  localparam int          TMO_MS  = 100;
  localparam int unsigned TMO_CYC = TMO_MS * CLK_KHZ;

  typedef struct packed {
    logic [23:0] detect;
    logic [23:0] error;
    logic [7:0]  x_fault;
    logic        y_fault;
    logic        any_cal;
    logic        cal_fail5;
    logic        low_ref;
    logic        sync_fail;
  } tkh_sense_s;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } tkh_nvm_s;

  typedef enum logic [1:0] {ST_RUN, ST_LOAD, ST_NVM} tkh_state_e;

endpackage

//--- tkh_crc8.sv
// one-byte crc-8 update step, msb first
`timescale 1ns/1ps
module tkh_crc8 (
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data,
  output logic      [7:0] crc_out
);
  import tkh_pkg::*;

  // eight shift-and-xor steps unrolled by the loop
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc_out = c;
  end

endmodule

//--- tkh_core.sv
// touch-key host command interpreter behind an spi slave link
//
// Notes on behaviour
// - one null byte shifts out one queued byte
// - setup entry halts sensing, then expects block
// - double commands need repeat within 100ms
// - 0xFE when ready, 0xFE after storing
// - block bytes over 100ms apart abort load
// - crc failure returns 0x00 as second ack
// - crc byte 0x00 skips the check
// - block stored whatever the crc result
// - sensing resumes after load; host resets later
// - calibrate all acks 0xFC, back to run
// - forced reset acks 0xFB then resets
// - status bits 6, 5, 3: comms, fault, sync
// - status bit 2: cal failed or low reference
// - status bit 1 calibrating, bit 0 detect
// - one-byte reports followed by crc-8
// - first-key bit 7: two or more touches
// - first-key bit 6: any error condition except low reference
// - low five bits key number or 0x1F
// - all-keys detect returns three bitfield bytes
// - three-byte reports followed by crc-8
// - line-fault byte holds x line bits
// - return-last-command clears comms error
// - key 0 at bit 0 of first byte
// - any y line fault gives 0xFF
`timescale 1ns/1ps
module tkh_core #(
  parameter int unsigned TMO_CYCLES = tkh_pkg::TMO_CYC
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               spi_sclk,
  input  wire logic               spi_mosi,
  input  wire logic               spi_ss_n,
  output logic                    spi_miso,
  output logic                    spi_miso_oe,
  input  wire tkh_pkg::tkh_sense_s sense,
  input  wire logic               nvm_busy,
  output tkh_pkg::tkh_nvm_s       nvm_wr,
  output logic                    sense_halt,
  output logic                    cal_all,
  output logic                    dev_reset
);
  import tkh_pkg::*;

  // commands that need a second identical byte to run
  function automatic logic is_dbl(input logic [7:0] c);
    return (c == CMD_SETUP) || (c == CMD_CAL) || (c == CMD_RST);
  endfunction

  // reports with one data byte plus crc
  function automatic logic is_one(input logic [7:0] c);
    return (c == CMD_GSTAT) || (c == CMD_FIRST) || (c == CMD_LFLT);
  endfunction

  // reports with three bitfield bytes plus crc
  function automatic logic is_three(input logic [7:0] c);
    return (c == CMD_ALLDET) || (c == CMD_ALLERR);
  endfunction

  // lowest touched key wins the first-key slot
  function automatic logic [4:0] first_key(input logic [23:0] d);
    logic [4:0] k;
    k = NO_KEY;
    for (int i = 23; i >= 0; i--) begin
      if (d[i]) k = 5'(i);
    end
    return k;
  endfunction

  logic [2:0]  pin_meta_r;
  logic [2:0]  pin_sync_r;
  logic        sclk_d_r;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  rx_sr_r;
  logic [7:0]  tx_sr_r;
  logic        miso_r;
  logic        miso_oe_r;
  logic [7:0]  q_r [0:QDEPTH-1];
  logic [1:0]  rd_r;
  logic [2:0]  len_r;
  logic [7:0]  last_cmd_r;
  logic        comm_err_r;
  logic        dbl_arm_r;
  logic [7:0]  dbl_cmd_r;
  logic [23:0] tmo_cnt_r;
  tkh_state_e  st_r;
  tkh_state_e  st_nxt;
  logic [6:0]  blk_cnt_r;
  logic [7:0]  blk_crc_r;
  logic        crc_ok_r;
  tkh_nvm_s    nvm_wr_r;
  logic        sense_halt_r;
  logic        cal_all_r;
  logic        rst_pend_r;
  logic        dev_reset_r;
  logic        q_ld;
  logic [2:0]  q_ld_len;
  logic [7:0]  q_ld_v [0:QDEPTH-1];

  // pins cross into clk by two flops; only the second stage is read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_r <= PIN_RST;
      pin_sync_r <= PIN_RST;
      sclk_d_r   <= 1'b0;
    end else begin
      pin_meta_r <= {spi_sclk, spi_mosi, spi_ss_n};
      pin_sync_r <= pin_meta_r;
      sclk_d_r   <= pin_sync_r[2];
    end
  end

  // link edges: sample on rise, drive on fall
  wire       sclk_s  = pin_sync_r[2];
  wire       mosi_s  = pin_sync_r[1];
  wire       ss_n_s  = pin_sync_r[0];
  wire       rise    = sclk_s & ~sclk_d_r & ~ss_n_s;
  wire       fall    = ~sclk_s & sclk_d_r & ~ss_n_s;
  wire       rx_done = rise && (bit_cnt_r == 3'h7);
  wire [7:0] rx_byte = {rx_sr_r[6:0], mosi_s};

  // receive shifter; deselect realigns the byte boundary
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_r <= 3'h0;
      rx_sr_r   <= 8'h00;
    end else if (ss_n_s) begin
      bit_cnt_r <= 3'h0;
    end else if (rise) begin
      bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      rx_sr_r   <= rx_byte;
    end
  end

  // status sources for the reports
  wire        fmea     = (|sense.x_fault) | sense.y_fault;
  wire        multi    = |(sense.detect & (sense.detect - 24'h000001));
  wire        any_err  = sense.any_cal | sense.cal_fail5 | sense.sync_fail
                         | comm_err_r | fmea;
  wire [7:0]  gstat;
  wire [7:0]  fkey;
  wire [7:0]  lflt     = sense.y_fault ? ALL_ONES : sense.x_fault;
  // key 0 lands in bit 0 of the first byte sent
  wire [23:0] kbits    = (rx_byte == CMD_ALLERR) ? sense.error : sense.detect;

  assign gstat[7]        = 1'b0;
  assign gstat[GS_COMM]  = comm_err_r;
  assign gstat[GS_FMEA]  = fmea;
  assign gstat[4]        = 1'b0;
  assign gstat[GS_SYNC]  = sense.sync_fail;
  assign gstat[GS_CALF]  = sense.cal_fail5 | sense.low_ref;
  assign gstat[GS_CAL]   = sense.any_cal;
  assign gstat[GS_DET]   = |sense.detect;

  assign fkey[FK_MULTI]  = multi;
  assign fkey[FK_ERR]    = any_err;
  assign fkey[5]         = 1'b0;
  assign fkey[4:0]       = first_key(sense.detect);

  // first data byte of each report
  wire [7:0] d0 = (rx_byte == CMD_GSTAT) ? gstat :
                  (rx_byte == CMD_FIRST) ? fkey  :
                  (rx_byte == CMD_LFLT)  ? lflt  : kbits[7:0];

  // crc chain over command byte then data bytes
  logic [7:0] crc_c [0:4];
  logic [7:0] crc_d [0:3];
  logic [7:0] blk_crc_nxt;
  assign crc_c[0] = CRC_INIT;
  assign crc_d[0] = rx_byte;
  assign crc_d[1] = d0;
  assign crc_d[2] = kbits[15:8];
  assign crc_d[3] = kbits[23:16];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_crc
      tkh_crc8 u_crc (
        .crc_in  (crc_c[g]),
        .data    (crc_d[g]),
        .crc_out (crc_c[g+1])
      );
    end
  endgenerate

  // running crc over the setups block
  tkh_crc8 u_blk_crc (
    .crc_in  (blk_crc_r),
    .data    (rx_byte),
    .crc_out (blk_crc_nxt)
  );

  // command decode in run state
  wire run_cmd  = rx_done && (st_r == ST_RUN) && (rx_byte != CMD_NULL);
  wire known    = is_dbl(rx_byte) || is_one(rx_byte) || is_three(rx_byte)
                  || (rx_byte == CMD_LAST);
  wire dbl_ok   = run_cmd && dbl_arm_r && (dbl_cmd_r == rx_byte) && is_dbl(rx_byte);
  wire do_setup = dbl_ok && (rx_byte == CMD_SETUP);
  wire do_cal   = dbl_ok && (rx_byte == CMD_CAL);
  wire do_rst   = dbl_ok && (rx_byte == CMD_RST);
  wire tmo_hit  = (dbl_arm_r || (st_r == ST_LOAD))
                  && (tmo_cnt_r == 24'(TMO_CYCLES - 1));
  wire blk_dat  = (st_r == ST_LOAD) && rx_done && (blk_cnt_r != BLK_LEN);
  wire blk_last = (st_r == ST_LOAD) && rx_done && (blk_cnt_r == BLK_LEN);
  wire nvm_done = (st_r == ST_NVM) && !nvm_busy;
  // in load, every data byte also clocks out the queued ack
  wire pop      = rx_done && (len_r != 3'h0)
                  && ((st_r != ST_RUN) || (rx_byte == CMD_NULL));
  wire [7:0] q_head = (len_r != 3'h0) ? q_r[rd_r] : IDLE_BYTE;

  // what a new command puts in the answer queue
  always_comb begin
    q_ld     = 1'b0;
    q_ld_len = 3'h0;
    for (int i = 0; i < QDEPTH; i++) q_ld_v[i] = IDLE_BYTE;
    if (run_cmd) begin
      q_ld = 1'b1; // unknown or first of a pair leaves the queue empty
      if (rx_byte == CMD_LAST) begin
        q_ld_v[0] = ~last_cmd_r;
        q_ld_len  = 3'h1;
      end else if (is_one(rx_byte)) begin
        q_ld_v[0] = d0;
        q_ld_v[1] = crc_c[2];
        q_ld_len  = 3'h2;
      end else if (is_three(rx_byte)) begin
        q_ld_v[0] = d0;
        q_ld_v[1] = kbits[15:8];
        q_ld_v[2] = kbits[23:16];
        q_ld_v[3] = crc_c[4];
        q_ld_len  = 3'h4;
      end else if (do_setup) begin
        q_ld_v[0] = ACK_SETUP;
        q_ld_len  = 3'h1;
      end else if (do_cal) begin
        q_ld_v[0] = ACK_CAL;
        q_ld_len  = 3'h1;
      end else if (do_rst) begin
        q_ld_v[0] = ACK_RST;
        q_ld_len  = 3'h1;
      end
    end else if (nvm_done) begin
      q_ld      = 1'b1;
      q_ld_v[0] = crc_ok_r ? ACK_SETUP : NAK_CRC;
      q_ld_len  = 3'h1;
    end
  end

  // answer queue: reload replaces stale bytes, null pops one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < QDEPTH; i++) q_r[i] <= IDLE_BYTE;
      rd_r  <= 2'h0;
      len_r <= 3'h0;
    end else if (q_ld) begin
      for (int i = 0; i < QDEPTH; i++) q_r[i] <= q_ld_v[i];
      rd_r  <= 2'h0;
      len_r <= q_ld_len;
    end else if (pop) begin
      rd_r  <= 2'(rd_r + 2'h1);
      len_r <= 3'(len_r - 3'h1);
    end
  end

  // transmit shifter; head is loaded at each byte boundary
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sr_r   <= 8'h00;
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= ~ss_n_s;
      if (ss_n_s || (fall && (bit_cnt_r == 3'h0))) begin
        miso_r  <= q_head[7];
        tx_sr_r <= {q_head[6:0], 1'b0};
      end else if (fall) begin
        miso_r  <= tx_sr_r[7];
        tx_sr_r <= {tx_sr_r[6:0], 1'b0};
      end
    end
  end

  // comms error: set wins over the clear from return-last-command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      comm_err_r <= 1'b0;
      last_cmd_r <= 8'h00;
    end else begin
      comm_err_r <= (run_cmd && !known)
                    || (comm_err_r && !(run_cmd && (rx_byte == CMD_LAST)));
      if (run_cmd) last_cmd_r <= rx_byte;
    end
  end

  // pairing: any other command or the timeout disarms
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbl_arm_r <= 1'b0;
      dbl_cmd_r <= 8'h00;
    end else if (run_cmd) begin
      dbl_arm_r <= is_dbl(rx_byte) && !dbl_ok;
      dbl_cmd_r <= rx_byte;
    end else if (tmo_hit) begin
      dbl_arm_r <= 1'b0;
    end
  end

  // one timer serves the pair window and the byte gap in load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmo_cnt_r <= 24'h000000;
    // nulls in run must not stretch the pair window
    end else if (run_cmd || (rx_done && (st_r == ST_LOAD)) || tmo_hit) begin
      tmo_cnt_r <= 24'h000000;
    end else if (dbl_arm_r || (st_r == ST_LOAD)) begin
      tmo_cnt_r <= 24'(tmo_cnt_r + 24'h000001);
    end
  end

  // load sequence
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN:  if (do_setup) st_nxt = ST_LOAD;
      ST_LOAD: begin
        if (blk_last) st_nxt = ST_NVM;
        else if (tmo_hit) st_nxt = ST_RUN;
      end
      ST_NVM:  if (nvm_done) st_nxt = ST_RUN;
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r         <= ST_RUN;
      sense_halt_r <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      sense_halt_r <= (st_nxt != ST_RUN);
    end
  end

  // block capture: every data byte goes to storage, good crc or not
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_cnt_r <= 7'h00;
      blk_crc_r <= CRC_INIT;
      crc_ok_r  <= 1'b0;
      nvm_wr_r  <= '0;
    end else begin
      nvm_wr_r.we   <= blk_dat;
      nvm_wr_r.addr <= blk_cnt_r;
      nvm_wr_r.data <= rx_byte;
      if (do_setup) begin
        blk_cnt_r <= 7'h00;
        blk_crc_r <= CRC_INIT;
      end else if (blk_dat) begin
        blk_cnt_r <= 7'(blk_cnt_r + 7'h01);
        blk_crc_r <= blk_crc_nxt;
      end
      if (blk_last) crc_ok_r <= (rx_byte == CRC_SKIP) || (rx_byte == blk_crc_r);
    end
  end

  // cal pulse at once; reset only after its ack is clocked out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_all_r   <= 1'b0;
      rst_pend_r  <= 1'b0;
      dev_reset_r <= 1'b0;
    end else begin
      cal_all_r   <= do_cal;
      dev_reset_r <= rst_pend_r && !dev_reset_r && (len_r == 3'h0) && !q_ld;
      if (do_rst) rst_pend_r <= 1'b1;
      else if (dev_reset_r) rst_pend_r <= 1'b0;
    end
  end

  assign spi_miso    = miso_r;
  assign spi_miso_oe = miso_oe_r;
  assign nvm_wr      = nvm_wr_r;
  assign sense_halt  = sense_halt_r;
  assign cal_all     = cal_all_r;
  assign dev_reset   = dev_reset_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_cmd(logic [7:0] c);
    rx_done && (st_r == ST_RUN) && (rx_byte == c);
  endsequence

  sequence s_paired(logic [7:0] c);
    s_cmd(c) ##0 (dbl_arm_r && (dbl_cmd_r == c));
  endsequence

  unknown_cmd_err_a: assert property (run_cmd && !known |=> comm_err_r && len_r == 3'h0)
    else $error("unknown command did not set comms error");
  last_cmd_clr_a: assert property (s_cmd(CMD_LAST) |=> !comm_err_r
                                   && q_r[0] == ~$past(last_cmd_r))
    else $error("return-last-command wrong");
  single_cal_a: assert property (s_cmd(CMD_CAL) ##0 !dbl_arm_r |=> !cal_all_r [*2])
    else $error("single calibrate byte executed");
  cal_ack_a: assert property (s_paired(CMD_CAL) |=> cal_all_r && q_r[0] == ACK_CAL)
    else $error("calibrate all not acknowledged");
  setup_enter_a: assert property (s_paired(CMD_SETUP) |=> st_r == ST_LOAD
                                  && q_r[0] == ACK_SETUP ##1 sense_halt_r)
    else $error("setup entry failed");
  load_tmo_a: assert property (st_r == ST_LOAD && tmo_hit && !rx_done
                               |=> st_r == ST_RUN ##1 !sense_halt_r)
    else $error("load timeout not taken");
  blk_store_a: assert property (blk_dat |=> nvm_wr_r.we
                                && nvm_wr_r.data == $past(rx_byte))
    else $error("block byte not stored");
  second_ack_a: assert property (nvm_done && !run_cmd |=> len_r == 3'h1
                                 && q_r[0] == ($past(crc_ok_r) ? ACK_SETUP : NAK_CRC))
    else $error("second acknowledge wrong");
  no_touch_a: assert property (s_cmd(CMD_FIRST) ##0 (sense.detect == 24'h000000)
                               |=> q_r[0][4:0] == NO_KEY)
    else $error("no touch not reported as 0x1F");
  yline_ff_a: assert property (s_cmd(CMD_LFLT) ##0 sense.y_fault |=> q_r[0] == ALL_ONES)
    else $error("y line fault not all ones");

endmodule

//--- tkh_host.sv
// host-side spi master model, mode 0, one frame per byte
`timescale 1ns/1ps
module tkh_host (
  input  wire logic clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      mosi,
  output logic      ss_n
);
  localparam int HALF = 10; // 80 ns half period of a 160 ns link clock

  initial begin
    sclk = 1'b0;
    mosi = 1'b1;
    ss_n = 1'b1;
  end

  // one byte each way; sclk stands low outside frames, one null per reply byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge clk);
    ss_n <= 1'b0;
    mosi <= tx[7];
    for (int b = 7; b >= 0; b--) begin
      repeat (HALF) @(posedge clk);
      sclk  <= 1'b1;
      rx[b] = miso; // taken at the rising edge, mode 0
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
      if (b > 0) mosi <= tx[b-1];
    end
    repeat (HALF) @(posedge clk);
    ss_n <= 1'b1;
    mosi <= ~tx[0]; // released line must not look like the last bit
    repeat (4) @(posedge clk);
  endtask
endmodule

//--- touch_key_host_command_set_bench.sv
// self-checking bench for the touch-key host command interpreter
`timescale 1ns/1ps
module touch_key_host_command_set_bench;
  import tkh_pkg::*;
  localparam int unsigned TMO = 2000; // short timeout keeps the run brief
  logic       clk        = 1'b0;
  logic       sys_rst    = 1'b1;
  logic       nvm_busy   = 1'b0;
  logic       comm_exp   = 1'b0;
  tkh_sense_s sense      = '0;
  logic       sclk, mosi, ss_n, miso, miso_oe, miso_w;
  logic       sense_halt, cal_all, dev_reset;
  tkh_nvm_s   nvm_wr;
  logic [7:0] blk [100];
  logic [7:0] got;
  logic [7:0] cmds [5] = '{CMD_GSTAT, CMD_FIRST, CMD_ALLDET, CMD_ALLERR, CMD_LFLT};
  int         err_total  = 0;
  int         checks     = 0;
  int         seed       = 32'h09534D54;
  int         cal_n = 0, rst_n = 0, wr_n = 0, wr_base = 0, busy_cnt = 0, cyc = 0;
  int         wr_i;

  always #4 clk = ~clk;
  // no pull on the wire: when not driven it shows no stale value
  assign miso_w = miso_oe ? miso : ~miso;
  // write index within the current load; only the monitor writes wr_n
  assign wr_i = wr_n - wr_base;

  tkh_core #(.TMO_CYCLES(TMO)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_mosi(mosi), .spi_ss_n(ss_n),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .sense(sense), .nvm_busy(nvm_busy),
    .nvm_wr(nvm_wr), .sense_halt(sense_halt), .cal_all(cal_all), .dev_reset(dev_reset));
  tkh_host host_u (.clk(clk), .miso(miso_w), .sclk(sclk), .mosi(mosi), .ss_n(ss_n));

  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic cmp(input logic [7:0] exp, input logic [7:0] act, input logic [7:0] mk,
                     input string m);
    checks++;
    if ((act & mk) !== (exp & mk)) begin
      err_total++;
      $display("mismatch at %0t: %s exp %h got %h", $time, m, exp, act);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // storage model busy a few cycles per write, pulse counters, watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (nvm_wr.we === 1'b1) begin
      chk(nvm_wr.addr === 7'(wr_i) && nvm_wr.data === blk[wr_i], "store write");
      wr_n <= wr_n + 1;
      busy_cnt <= 6;
    end else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    nvm_busy <= (nvm_wr.we === 1'b1) || busy_cnt > 1;
    if (cal_all === 1'b1) cal_n <= cal_n + 1;
    if (dev_reset === 1'b1) rst_n <= rst_n + 1;
    if (cyc > 99000) begin
      chk(1'b0, "run too long");
      conclude();
    end
  end

  function automatic logic [7:0] crc_up(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction

  function automatic logic [7:0] gstat_of(input tkh_sense_s s, input logic ce);
    return {1'b0, ce, (|s.x_fault) | s.y_fault, 1'b0, s.sync_fail,
            s.cal_fail5 | s.low_ref, s.any_cal, |s.detect};
  endfunction

  // lowest touched key taken as first; only bits 7..5 judged when several touch
  function automatic logic [7:0] first_of(input tkh_sense_s s, input logic ce);
    logic [4:0] k;
    k = NO_KEY;
    for (int i = 23; i >= 0; i--) if (s.detect[i]) k = 5'(i);
    return {$countones(s.detect) > 1, s.any_cal | s.cal_fail5 | s.sync_fail | ce
            | (|s.x_fault) | s.y_fault, 1'b0, k};
  endfunction

  task automatic report(input logic [7:0] cmd);
    logic [7:0] d [3];
    logic [7:0] c, mk;
    int n;
    n = (cmd == CMD_ALLDET || cmd == CMD_ALLERR) ? 3 : 1;
    mk = (cmd == CMD_FIRST && $countones(sense.detect) > 1) ? 8'hE0 : 8'hFF;
    case (cmd)
      CMD_GSTAT:  d[0] = gstat_of(sense, comm_exp);
      CMD_FIRST:  d[0] = first_of(sense, comm_exp);
      CMD_LFLT:   d[0] = sense.y_fault ? ALL_ONES : sense.x_fault;
      CMD_ALLDET: {d[2], d[1], d[0]} = sense.detect;
      default:    {d[2], d[1], d[0]} = sense.error;
    endcase
    c = crc_up(CRC_INIT, cmd);
    host_u.xfer(cmd, got);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(CMD_NULL, got);
      cmp(d[i], got, mk, "report");
      c = crc_up(c, (d[i] & mk) | (got & ~mk));
    end
    host_u.xfer(CMD_NULL, got);
    cmp(c, got, 8'hFF, "report crc");
  endtask

  task automatic pair(input logic [7:0] cmd);
    host_u.xfer(cmd, got);
    host_u.xfer(cmd, got);
  endtask

  task automatic halt_gone(input string m);
    int n;
    n = 0;
    while (sense_halt !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 3000, m);
  endtask

  // main sequence
  initial begin
    int c0;
    logic [7:0] bc;
    logic [95:0] r;
    tkh_sense_s s;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(miso_oe === 1'b0 && sense_halt === 1'b0 && cal_n == 0, "idle after reset");
    // random sensing states through every report command
    for (int it = 0; it < 15; it++) begin
      r = {$random(seed), $random(seed), $random(seed)};
      s = tkh_sense_s'(r[60:0]);
      if (it % 3 == 0) s.detect = '0;
      if (it % 3 == 1) s.detect = 24'(1) << (r[95:91] % 24);
      if (it == 9) s.y_fault = 1'b1; // corner: a y line fault in a line-fault report
      @(posedge clk);
      sense <= s;
      repeat (4) @(posedge clk);
      report(cmds[it % 5]);
    end
    // unknown command, then clearing the comms flag
    host_u.xfer(8'h22, got);
    host_u.xfer(CMD_NULL, got);
    cmp(IDLE_BYTE, got, 8'hFF, "unknown answered");
    comm_exp = 1'b1;
    report(CMD_GSTAT);
    host_u.xfer(CMD_LAST, got);
    host_u.xfer(CMD_NULL, got);
    cmp(~CMD_GSTAT, got, 8'hFF, "last command");
    comm_exp = 1'b0;
    report(CMD_FIRST);
    // calibrate pair, then a pair split by the timeout
    c0 = cal_n;
    pair(CMD_CAL);
    host_u.xfer(CMD_NULL, got);
    cmp(ACK_CAL, got, 8'hFF, "cal ack");
    chk(cal_n == c0 + 1, "cal pulse");
    host_u.xfer(CMD_CAL, got);
    repeat (TMO + 100) @(posedge clk);
    host_u.xfer(CMD_CAL, got);
    host_u.xfer(CMD_NULL, got);
    cmp(IDLE_BYTE, got, 8'hFF, "late pair");
    chk(cal_n == c0 + 1, "late pair cal");
    // another command between the two bytes breaks the pair
    report(CMD_LFLT);
    host_u.xfer(CMD_CAL, got);
    chk(cal_n == c0 + 1, "split pair cal");
    c0 = rst_n;
    pair(CMD_RST);
    host_u.xfer(CMD_NULL, got);
    cmp(ACK_RST, got, 8'hFF, "reset ack");
    repeat (10) @(posedge clk);
    chk(rst_n == c0 + 1, "reset pulse");
    // block loads: good crc, bad crc, skipped crc
    for (int m = 0; m < 3; m++) begin
      foreach (blk[i]) blk[i] = 8'($random(seed));
      bc = CRC_INIT;
      foreach (blk[i]) bc = crc_up(bc, blk[i]);
      if (m == 1) bc = (bc == 8'hFF) ? 8'h01 : bc + 8'h01;
      if (m == 2) bc = CRC_SKIP;
      wr_base = wr_n;
      pair(CMD_SETUP);
      repeat (20) @(posedge clk);
      chk(sense_halt === 1'b1, "halt on entry");
      foreach (blk[i]) begin
        host_u.xfer(blk[i], got);
        if (i == 0) cmp(ACK_SETUP, got, 8'hFF, "ready ack");
      end
      host_u.xfer(bc, got);
      halt_gone("sensing resumes");
      chk(wr_n == wr_base + 100, "block stored");
      host_u.xfer(CMD_NULL, got);
      cmp(m == 1 ? NAK_CRC : ACK_SETUP, got, 8'hFF, "final ack");
    end
    // stalled load is abandoned without an ack
    blk[0] = 8'h5A;
    blk[1] = 8'hA5;
    wr_base = wr_n;
    pair(CMD_SETUP);
    host_u.xfer(8'h5A, got);
    host_u.xfer(8'hA5, got);
    repeat (TMO + 100) @(posedge clk);
    chk(sense_halt === 1'b0, "load abandoned");
    host_u.xfer(CMD_NULL, got);
    cmp(IDLE_BYTE, got, 8'hFF, "no ack after stall");
    conclude();
  end
endmodule
